// ==== rtl/pdh_event_reg.sv ====
module pdh_event_reg #(
	parameter int W = 4
) (
	// Clock and reset.
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Event sources and software access.
	input  wire logic [W-1:0] set_in,
	input  wire logic [W-1:0] clr_in,
	input  wire logic         mask_we_in,
	input  wire logic [W-1:0] mask_in,
	// State and interrupt.
	output logic      [W-1:0] status_out,
	output logic      [W-1:0] mask_out,
	output logic              irq_out
);

	logic [W-1:0] status_q;
	logic [W-1:0] status_d;
	logic [W-1:0] mask_q;
	logic [W-1:0] mask_d;
	logic         irq_q;
	logic         irq_d;

	// A hardware set in the same cycle as a write-one clear keeps the bit set.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			status_d[i] = set_in[i] | (status_q[i] & ~clr_in[i]);
			mask_d[i]   = mask_we_in ? mask_in[i] : mask_q[i];
		end
	end

	always_comb begin
		irq_d = |(status_d & mask_d);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_q <= '0;
			mask_q   <= '0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= irq_d;
		end
	end

	assign status_out = status_q;
	assign mask_out   = mask_q;
	assign irq_out    = irq_q;

endmodule

// ==== rtl/pdh_pkg.sv ====
package pdh_pkg;

	// Descriptor word offsets from the descriptor base address.
	localparam logic [31:0] DESC_LINK_OFS       = 32'h0000_0000;
	localparam logic [31:0] DESC_CMD_OFS        = 32'h0000_0004;
	localparam logic [31:0] DESC_PTR_OFS        = 32'h0000_0008;
	localparam logic [31:0] DESC_PTR_LEGACY_OFS = 32'h0000_000c;
	localparam logic [31:0] WORD_ALIGN_MASK     = 32'hffff_fffc;

	// Command/status word layout.
	localparam int CS_OWN     = 31;
	localparam int CS_MORE    = 30;
	localparam int CS_COMPLETION_IRQ_REQUEST    = 29;
	localparam int CS_FCS     = 28;
	localparam int CS_OK      = 27;
	localparam int CS_STAT_HI = 26;
	localparam int CS_STAT_LO = 16;
	localparam int CS_RSV_HI  = 15;
	localparam int CS_RSV_LO  = 12;
	localparam int CS_SIZE_HI = 11;
	localparam int STAT_W     = CS_STAT_HI - CS_STAT_LO + 1;
	localparam int SIZE_W     = CS_SIZE_HI + 1;
	localparam int RSV_W      = CS_RSV_HI - CS_RSV_LO + 1;

	// Register byte addresses.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_TX_PTR = 8'h04;
	localparam logic [7:0] REG_RX_PTR = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_MASK   = 8'h10;
	localparam logic [7:0] REG_STATE  = 8'h14;

	// Control register fields.
	localparam int CTRL_TX_GO  = 0;
	localparam int CTRL_RX_GO  = 1;
	localparam int CTRL_LEGACY = 2;

	// Event bits of the status and mask registers.
	localparam int EV_TX_DESC = 0;
	localparam int EV_RX_DESC = 1;
	localparam int EV_TX_IDLE = 2;
	localparam int EV_RX_IDLE = 3;
	localparam int EV_W       = 4;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		PDH_IDLE,
		PDH_RD_CMD,
		PDH_RD_PTR,
		PDH_RD_LINK,
		PDH_FRAG,
		PDH_WR_CMD
	} pdh_state_t;

endpackage

// ==== rtl/pdh_top.sv ====
module pdh_top (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Avalon-MM register slave.
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Descriptor memory master.
	output logic             mem_read_out,
	output logic             mem_write_out,
	output logic      [31:0] mem_addr_out,
	output logic      [31:0] mem_wdata_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	// Fragment handoff to the data path.
	output logic             frag_valid_out,
	output logic             frag_tx_out,
	output logic      [31:0] frag_addr_out,
	output logic      [11:0] frag_len_out,
	output logic             frag_last_out,
	output logic             fcs_append_inhibit_out,
	input  wire logic        frag_done_in,
	input  wire logic        frag_ok_in,
	input  wire logic        frag_last_in,
	input  wire logic [11:0] frag_len_in,
	input  wire logic [10:0] frag_stat_in,
	// Interrupt.
	output logic             completion_irq_request_out
);

	pdh_pkg::pdh_state_t state_q, state_d;

	logic        dir_tx_q, dir_tx_d;
	logic        last_tx_q, last_tx_d;
	logic        tx_act_q, tx_act_d;
	logic        rx_act_q, rx_act_d;
	logic        legacy_layout_select_q, legacy_layout_select_d;
	logic [31:0] tx_cur_q, tx_cur_d;
	logic [31:0] rx_cur_q, rx_cur_d;
	logic [31:0] cmd_q, cmd_d;
	logic [31:0] link_q, link_d;
	logic        mem_read_q, mem_read_d;
	logic        mem_write_q, mem_write_d;
	logic [31:0] mem_addr_q, mem_addr_d;
	logic [31:0] mem_wdata_q, mem_wdata_d;
	logic        frag_valid_q, frag_valid_d;
	logic [31:0] frag_addr_q, frag_addr_d;
	logic [11:0] frag_len_q, frag_len_d;
	logic        frag_last_q, frag_last_d;
	logic        fcs_inhibit_q, fcs_inhibit_d;
	logic        wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;

	logic                    wr_hit;
	logic                    rd_take;
	logic [31:0]             cur;
	logic [31:0]             ptr_ofs;
	logic                    owned;
	logic                    pick_tx;
	logic [pdh_pkg::EV_W-1:0] ev_set;
	logic [pdh_pkg::EV_W-1:0] ev_clr;
	logic [pdh_pkg::EV_W-1:0] ev_status;
	logic [pdh_pkg::EV_W-1:0] ev_mask;
	logic                    irq;

	// The bus answers one cycle after a request: waitrequest drops for one cycle.
	always_comb begin
		wr_hit  = avs_write_in && !wait_q;
		rd_take = avs_read_in && wait_q;
		wait_d  = !((avs_read_in || avs_write_in) && wait_q);
		rdata_d = rdata_q;
		if (rd_take) begin
			unique case (avs_address_in)
				pdh_pkg::REG_CTRL: begin
					rdata_d = {29'h0, legacy_layout_select_q, rx_act_q, tx_act_q};
				end
				pdh_pkg::REG_TX_PTR: begin
					rdata_d = tx_cur_q;
				end
				pdh_pkg::REG_RX_PTR: begin
					rdata_d = rx_cur_q;
				end
				pdh_pkg::REG_STATUS: begin
					rdata_d = {28'h000_0000, ev_status};
				end
				pdh_pkg::REG_MASK: begin
					rdata_d = {28'h000_0000, ev_mask};
				end
				pdh_pkg::REG_STATE: begin
					rdata_d = {27'h0, dir_tx_q, 1'b0, state_q};
				end
				default: begin
					rdata_d = pdh_pkg::RESET_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_q  <= 1'b1;
			rdata_q <= pdh_pkg::RESET_WORD;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Descriptor engine shared by the transmit and receive lists.
	always_comb begin
		state_d                = state_q;
		dir_tx_d               = dir_tx_q;
		last_tx_d              = last_tx_q;
		tx_act_d               = tx_act_q;
		rx_act_d               = rx_act_q;
		legacy_layout_select_d = legacy_layout_select_q;
		tx_cur_d               = tx_cur_q;
		rx_cur_d               = rx_cur_q;
		cmd_d                  = cmd_q;
		link_d                 = link_q;
		mem_read_d             = mem_read_q;
		mem_write_d            = mem_write_q;
		mem_addr_d             = mem_addr_q;
		mem_wdata_d            = mem_wdata_q;
		frag_valid_d           = frag_valid_q;
		frag_addr_d            = frag_addr_q;
		frag_len_d             = frag_len_q;
		frag_last_d            = frag_last_q;
		fcs_inhibit_d          = fcs_inhibit_q;
		ev_set                 = '0;
		cur                    = dir_tx_q ? tx_cur_q : rx_cur_q;
		ptr_ofs                = legacy_layout_select_q ? pdh_pkg::DESC_PTR_LEGACY_OFS
		                                                : pdh_pkg::DESC_PTR_OFS;
		// The device owns transmit words at one and receive words at zero.
		owned                  = mem_rdata_in[pdh_pkg::CS_OWN] == dir_tx_q;
		pick_tx                = tx_act_q && (!rx_act_q || !last_tx_q);
		unique case (state_q)
			pdh_pkg::PDH_IDLE: begin
				if (tx_act_q || rx_act_q) begin
					dir_tx_d   = pick_tx;
					mem_read_d = 1'b1;
					mem_addr_d = (pick_tx ? tx_cur_q : rx_cur_q) + pdh_pkg::DESC_CMD_OFS;
					state_d    = pdh_pkg::PDH_RD_CMD;
				end
			end
			pdh_pkg::PDH_RD_CMD: begin
				if (mem_ack_in) begin
					cmd_d = mem_rdata_in;
					if (owned) begin
						mem_addr_d = cur + ptr_ofs;
						state_d    = pdh_pkg::PDH_RD_PTR;
					end else begin
						mem_read_d = 1'b0;
						if (dir_tx_q) begin
							tx_act_d                   = 1'b0;
							ev_set[pdh_pkg::EV_TX_IDLE] = 1'b1;
						end else begin
							rx_act_d                   = 1'b0;
							ev_set[pdh_pkg::EV_RX_IDLE] = 1'b1;
						end
						state_d = pdh_pkg::PDH_IDLE;
					end
				end
			end
			pdh_pkg::PDH_RD_PTR: begin
				if (mem_ack_in) begin
					// Receive buffers are word aligned; transmit may start on any byte.
					frag_addr_d = dir_tx_q ? mem_rdata_in
					                       : (mem_rdata_in & pdh_pkg::WORD_ALIGN_MASK);
					mem_addr_d  = cur + pdh_pkg::DESC_LINK_OFS;
					state_d     = pdh_pkg::PDH_RD_LINK;
				end
			end
			pdh_pkg::PDH_RD_LINK: begin
				if (mem_ack_in) begin
					mem_read_d    = 1'b0;
					link_d        = mem_rdata_in & pdh_pkg::WORD_ALIGN_MASK;
					// Exactly one fragment is handed out per descriptor.
					frag_valid_d  = 1'b1;
					frag_len_d    = cmd_q[pdh_pkg::CS_SIZE_HI:0];
					frag_last_d   = !cmd_q[pdh_pkg::CS_MORE];
					fcs_inhibit_d = dir_tx_q && cmd_q[pdh_pkg::CS_FCS];
					state_d       = pdh_pkg::PDH_FRAG;
				end
			end
			pdh_pkg::PDH_FRAG: begin
				if (frag_done_in) begin
					frag_valid_d = 1'b0;
					mem_write_d  = 1'b1;
					mem_addr_d   = cur + pdh_pkg::DESC_CMD_OFS;
					if (dir_tx_q) begin
						mem_wdata_d = {1'b0, cmd_q[pdh_pkg::CS_MORE:pdh_pkg::CS_FCS],
						               !cmd_q[pdh_pkg::CS_MORE] && frag_ok_in,
						               frag_stat_in,
						               {pdh_pkg::RSV_W{1'b0}},
						               cmd_q[pdh_pkg::CS_SIZE_HI:0]};
					end else begin
						mem_wdata_d = {1'b1, !frag_last_in, cmd_q[pdh_pkg::CS_COMPLETION_IRQ_REQUEST],
						               1'b1,
						               frag_last_in && frag_ok_in,
						               frag_stat_in,
						               {pdh_pkg::RSV_W{1'b0}},
						               frag_len_in};
					end
					state_d = pdh_pkg::PDH_WR_CMD;
				end
			end
			pdh_pkg::PDH_WR_CMD: begin
				if (mem_ack_in) begin
					mem_write_d = 1'b0;
					last_tx_d   = dir_tx_q;
					if (dir_tx_q) begin
						tx_cur_d                   = link_q;
						ev_set[pdh_pkg::EV_TX_DESC] = cmd_q[pdh_pkg::CS_COMPLETION_IRQ_REQUEST];
					end else begin
						rx_cur_d                   = link_q;
						ev_set[pdh_pkg::EV_RX_DESC] = cmd_q[pdh_pkg::CS_COMPLETION_IRQ_REQUEST];
					end
					state_d = pdh_pkg::PDH_IDLE;
				end
			end
		endcase
		// Software writes take effect last, so a go request wins over an idle stop.
		if (wr_hit) begin
			unique case (avs_address_in)
				pdh_pkg::REG_CTRL: begin
					tx_act_d               = tx_act_d | avs_writedata_in[pdh_pkg::CTRL_TX_GO];
					rx_act_d               = rx_act_d | avs_writedata_in[pdh_pkg::CTRL_RX_GO];
					legacy_layout_select_d = avs_writedata_in[pdh_pkg::CTRL_LEGACY];
				end
				pdh_pkg::REG_TX_PTR: begin
					tx_cur_d = avs_writedata_in & pdh_pkg::WORD_ALIGN_MASK;
				end
				pdh_pkg::REG_RX_PTR: begin
					rx_cur_d = avs_writedata_in & pdh_pkg::WORD_ALIGN_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	assign ev_clr = (wr_hit && avs_address_in == pdh_pkg::REG_STATUS)
	                ? avs_writedata_in[pdh_pkg::EV_W-1:0] : '0;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q                <= pdh_pkg::PDH_IDLE;
			dir_tx_q               <= 1'b0;
			last_tx_q              <= 1'b0;
			tx_act_q               <= 1'b0;
			rx_act_q               <= 1'b0;
			legacy_layout_select_q <= 1'b0;
			tx_cur_q               <= pdh_pkg::RESET_WORD;
			rx_cur_q               <= pdh_pkg::RESET_WORD;
			cmd_q                  <= pdh_pkg::RESET_WORD;
			link_q                 <= pdh_pkg::RESET_WORD;
			mem_read_q             <= 1'b0;
			mem_write_q            <= 1'b0;
			mem_addr_q             <= pdh_pkg::RESET_WORD;
			mem_wdata_q            <= pdh_pkg::RESET_WORD;
			frag_valid_q           <= 1'b0;
			frag_addr_q            <= pdh_pkg::RESET_WORD;
			frag_len_q             <= '0;
			frag_last_q            <= 1'b0;
			fcs_inhibit_q          <= 1'b0;
		end else begin
			state_q                <= state_d;
			dir_tx_q               <= dir_tx_d;
			last_tx_q              <= last_tx_d;
			tx_act_q               <= tx_act_d;
			rx_act_q               <= rx_act_d;
			legacy_layout_select_q <= legacy_layout_select_d;
			tx_cur_q               <= tx_cur_d;
			rx_cur_q               <= rx_cur_d;
			cmd_q                  <= cmd_d;
			link_q                 <= link_d;
			mem_read_q             <= mem_read_d;
			mem_write_q            <= mem_write_d;
			mem_addr_q             <= mem_addr_d;
			mem_wdata_q            <= mem_wdata_d;
			frag_valid_q           <= frag_valid_d;
			frag_addr_q            <= frag_addr_d;
			frag_len_q             <= frag_len_d;
			frag_last_q            <= frag_last_d;
			fcs_inhibit_q          <= fcs_inhibit_d;
		end
	end

	pdh_event_reg #(
		.W (pdh_pkg::EV_W)
	) u_events (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.set_in     (ev_set),
		.clr_in     (ev_clr),
		.mask_we_in (wr_hit && avs_address_in == pdh_pkg::REG_MASK),
		.mask_in    (avs_writedata_in[pdh_pkg::EV_W-1:0]),
		.status_out (ev_status),
		.mask_out   (ev_mask),
		.irq_out    (irq)
	);

	assign avs_readdata_out           = rdata_q;
	assign avs_waitrequest_out        = wait_q;
	assign mem_read_out               = mem_read_q;
	assign mem_write_out              = mem_write_q;
	assign mem_addr_out               = mem_addr_q;
	assign mem_wdata_out              = mem_wdata_q;
	assign frag_valid_out             = frag_valid_q;
	assign frag_tx_out                = dir_tx_q;
	assign frag_addr_out              = frag_addr_q;
	assign frag_len_out               = frag_len_q;
	assign frag_last_out              = frag_last_q;
	assign fcs_append_inhibit_out     = fcs_inhibit_q;
	assign completion_irq_request_out = irq;

endmodule

// ==== test/pdh_mem_model.sv ====
module pdh_mem_model (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Answer speed.
	input  wire logic        slow_in,
	// Descriptor memory port.
	input  wire logic        read_in,
	input  wire logic        write_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	output logic             ack_out,
	output logic      [31:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [0:63];
	logic [1:0]  wait_q;
	// Read data toggle outside the ack cycle so a stale word is never mistaken for an answer.
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_out <= 1'b0;
			wait_q <= 2'h0;
			rdata_out <= 32'h0;
		end else begin
			rdata_out <= ~rdata_out;
			ack_out <= 1'b0;
			if (!ack_out && (read_in || write_in)) begin
				if (wait_q != 2'h0) begin
					wait_q <= wait_q - 2'h1;
				end else begin
					ack_out <= 1'b1;
					wait_q <= slow_in ? 2'h3 : 2'h0;
					if (write_in) begin
						mem[addr_in[7:2]] <= wdata_in;
					end else begin
						rdata_out <= mem[addr_in[7:2]];
					end
				end
			end
		end
	end
endmodule

// ==== test/pdh_monitor.sv ====
module pdh_monitor (
	// Clock and reset.
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	// Register bus.
	input wire logic [7:0]  avs_address_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic        avs_waitrequest_out,
	// Memory master.
	input wire logic        mem_read_out,
	input wire logic        mem_write_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic [31:0] mem_wdata_out,
	input wire logic        mem_ack_in,
	input wire logic [31:0] mem_rdata_in,
	// Fragment port.
	input wire logic        frag_valid_out,
	input wire logic        frag_tx_out,
	input wire logic [31:0] frag_addr_out,
	input wire logic [11:0] frag_len_out,
	input wire logic        frag_last_out,
	input wire logic        fcs_append_inhibit_out,
	input wire logic        frag_done_in,
	input wire logic        frag_ok_in,
	input wire logic        frag_last_in,
	input wire logic [11:0] frag_len_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0]  cnt_q, cnt_d;
	logic [31:0] base_q, base_d, cmd_q, cmd_d, desc_b;
	logic        leg_q, leg_d;
	assign desc_b = base_q - pdh_pkg::DESC_CMD_OFS;
	// Counts the reads of one descriptor and keeps the command word and its address.
	always_comb begin
		cnt_d = cnt_q;
		base_d = base_q;
		cmd_d = cmd_q;
		leg_d = leg_q;
		if (!mem_read_out) begin
			cnt_d = 2'h0;
		end else if (mem_ack_in) begin
			cnt_d = cnt_q + 2'h1;
		end
		if (mem_read_out && cnt_q == 2'h0) begin
			base_d = mem_addr_out;
			if (mem_ack_in) begin
				cmd_d = mem_rdata_in;
			end
		end
		if (avs_write_in && !avs_waitrequest_out && avs_address_in == pdh_pkg::REG_CTRL) begin
			leg_d = avs_writedata_in[pdh_pkg::CTRL_LEGACY];
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 2'h0;
			base_q <= 32'h0;
			cmd_q <= 32'h0;
			leg_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			base_q <= base_d;
			cmd_q <= cmd_d;
			leg_q <= leg_d;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_desc_aligned: assert property (
		mem_read_out && cnt_q == 2'h0 |-> mem_addr_out[1:0] == 2'h0)
		else $error("descriptor address not word aligned");
	a_ptr_offset: assert property (mem_read_out && cnt_q == 2'h1 |-> mem_addr_out == desc_b
		+ (leg_q ? pdh_pkg::DESC_PTR_LEGACY_OFS : pdh_pkg::DESC_PTR_OFS))
		else $error("buffer pointer fetched from wrong offset");
	a_link_offset: assert property (
		mem_read_out && cnt_q == 2'h2 |-> mem_addr_out == desc_b + pdh_pkg::DESC_LINK_OFS)
		else $error("link fetched from wrong offset");
	a_frag_offer: assert property (!mem_read_out && cnt_q == 2'h3 |-> frag_valid_out)
		else $error("no fragment offered after descriptor fetch");
	a_tx_fields: assert property (frag_valid_out && frag_tx_out |->
		fcs_append_inhibit_out == cmd_q[28] && frag_len_out == cmd_q[11:0]
		&& frag_last_out == !cmd_q[30]) else $error("transmit fragment fields differ");
	a_rx_fields: assert property (frag_valid_out && !frag_tx_out |->
		frag_addr_out[1:0] == 2'h0 && !fcs_append_inhibit_out)
		else $error("receive fragment fields wrong");
	a_return_word: assert property (frag_valid_out && frag_done_in |=>
		mem_write_out && mem_addr_out == base_q && mem_wdata_out[29] == cmd_q[29]
		&& mem_wdata_out[15:12] == 4'h0) else $error("returned command word wrong");
	a_tx_status: assert property (frag_valid_out && frag_done_in && frag_tx_out |=>
		mem_wdata_out[31:27] == {1'b0, cmd_q[30:28], $past(frag_ok_in) && !cmd_q[30]}
		&& mem_wdata_out[11:0] == cmd_q[11:0]) else $error("transmit status word wrong");
	a_rx_status: assert property (frag_valid_out && frag_done_in && !frag_tx_out |=>
		mem_wdata_out[31:27] == {1'b1, !$past(frag_last_in), cmd_q[29], 1'b1,
		$past(frag_last_in) && $past(frag_ok_in)} && mem_wdata_out[11:0] == $past(frag_len_in))
		else $error("receive status word wrong");
endmodule

bind pdh_top pdh_monitor pdh_monitor_i (.clk_in, .rst_n_in, .avs_address_in, .avs_write_in,
	.avs_writedata_in, .avs_waitrequest_out, .mem_read_out, .mem_write_out, .mem_addr_out,
	.mem_wdata_out, .mem_ack_in, .mem_rdata_in, .frag_valid_out, .frag_tx_out, .frag_addr_out,
	.frag_len_out, .frag_last_out, .fcs_append_inhibit_out, .frag_done_in, .frag_ok_in,
	.frag_last_in, .frag_len_in);

// ==== test/pdh_top_test.sv ====
module pdh_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, slow;
	logic [7:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
	logic        mem_read_out, mem_write_out, mem_ack_in, completion_irq_request_out;
	logic        frag_valid_out, frag_tx_out, frag_last_out, fcs_append_inhibit_out;
	logic        frag_done_in, frag_ok_in, frag_last_in;
	logic [31:0] frag_addr_out, q;
	logic [11:0] frag_len_out, frag_len_in;
	logic [10:0] frag_stat_in;
	int          n_fail, tests_run, seed;
	pdh_top pdh_top_i (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .mem_read_out,
		.mem_write_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in,
		.frag_valid_out, .frag_tx_out, .frag_addr_out, .frag_len_out, .frag_last_out,
		.fcs_append_inhibit_out, .frag_done_in, .frag_ok_in, .frag_last_in, .frag_len_in,
		.frag_stat_in, .completion_irq_request_out);
	pdh_mem_model pdh_mem_model_i (.clk_in, .rst_n_in, .slow_in(slow), .read_in(mem_read_out),
		.write_in(mem_write_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
		.ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
	task final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One register access; the request is held until the edge that samples waitrequest low.
	task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		avs_writedata_in <= d;
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task put(input logic [31:0] a, input logic [31:0] d);
		pdh_mem_model_i.mem[a[7:2]] = d;
	endtask
	task wait_status(input int b);
		int n;
		n = 0;
		q = 32'h0;
		while (q[b] !== 1'b1 && n < 50) begin
			av(1'b0, pdh_pkg::REG_STATUS, 32'h0);
			n++;
		end
	endtask
	// Plays the data path for one fragment and predicts the word written back.
	task serve(input logic tx, input logic [31:0] base, input logic [31:0] cmd, input logic [31:0] ptr);
		logic [31:0] exp, wa;
		wa = base + pdh_pkg::DESC_CMD_OFS;
		while (frag_valid_out !== 1'b1) begin
			@(negedge clk_in);
		end
		check("frag_tx", 32'(frag_tx_out), 32'(tx));
		check("frag_addr", frag_addr_out, tx ? ptr : ptr & pdh_pkg::WORD_ALIGN_MASK);
		check("frag_len", 32'(frag_len_out), 32'(cmd[11:0]));
		check("frag_last", 32'(frag_last_out), 32'(!cmd[30]));
		check("fcs_inhibit", 32'(fcs_append_inhibit_out), 32'(tx & cmd[28]));
		@(posedge clk_in);
		frag_done_in <= 1'b1;
		frag_ok_in <= 1'($random(seed));
		frag_last_in <= 1'($random(seed));
		frag_len_in <= 12'($random(seed)) & 12'h7ff;
		frag_stat_in <= 11'($random(seed));
		slow <= 1'($random(seed));
		@(posedge clk_in);
		frag_done_in <= 1'b0;
		exp = tx ? {1'b0, cmd[30:28], frag_ok_in & !cmd[30], frag_stat_in, 4'h0, cmd[11:0]}
			: {2'b10 | {1'b0, !frag_last_in}, cmd[29], 1'b1, frag_last_in & frag_ok_in,
			frag_stat_in, 4'h0, frag_len_in};
		while ((mem_write_out && mem_ack_in) !== 1'b1) begin
			@(negedge clk_in);
		end
		@(posedge clk_in);
		check("status_word", pdh_mem_model_i.mem[wa[7:2]], exp);
	endtask
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		final_report();
	end
	initial begin
		seed = 1;
		n_fail = 0;
		tests_run = 0;
		{rst_n_in, avs_read_in, avs_write_in, slow, frag_done_in, frag_ok_in, frag_last_in} = 7'h0;
		{avs_address_in, avs_writedata_in, frag_len_in, frag_stat_in} = 63'h0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		av(1'b0, pdh_pkg::REG_MASK, 32'h0);
		check("mask_reset", q, 32'h0);
		av(1'b1, pdh_pkg::REG_TX_PTR, 32'h43);
		av(1'b0, pdh_pkg::REG_TX_PTR, 32'h0);
		check("tx_ptr", q, 32'h40);
		av(1'b1, pdh_pkg::REG_MASK, 32'h1);
		// The first link carries set low bits on purpose; the engine must ignore them.
		put(32'h40, 32'h52);
		put(32'h44, 32'hf000_0123);
		put(32'h48, 32'h101);
		put(32'h50, 32'h60);
		put(32'h54, 32'h8000_0004);
		put(32'h58, 32'h202);
		put(32'h64, 32'h0);
		av(1'b1, pdh_pkg::REG_CTRL, 32'h1);
		serve(1'b1, 32'h40, 32'hf000_0123, 32'h101);
		serve(1'b1, 32'h50, 32'h8000_0004, 32'h202);
		wait_status(pdh_pkg::EV_TX_IDLE);
		check("status_tx", q, 32'h5);
		check("irq_tx", 32'(completion_irq_request_out), 32'h1);
		av(1'b0, pdh_pkg::REG_TX_PTR, 32'h0);
		check("tx_ptr_end", q, 32'h60);
		av(1'b1, pdh_pkg::REG_STATUS, 32'hf);
		av(1'b0, pdh_pkg::REG_STATUS, 32'h0);
		check("status_clr", q, 32'h0);
		check("irq_clr", 32'(completion_irq_request_out), 32'h0);
		av(1'b0, 8'h20, 32'h0);
		check("unmapped", q, 32'h0);
		put(32'h80, 32'h90);
		put(32'h84, 32'h2000_0400);
		put(32'h88, 32'hffff_ffff);
		put(32'h8c, 32'h303);
		put(32'h94, 32'h8000_0000);
		av(1'b1, pdh_pkg::REG_RX_PTR, 32'h80);
		av(1'b1, pdh_pkg::REG_CTRL, 32'h6);
		serve(1'b0, 32'h80, 32'h2000_0400, 32'h303);
		wait_status(pdh_pkg::EV_RX_IDLE);
		check("status_rx", q, 32'ha);
		check("irq_masked", 32'(completion_irq_request_out), 32'h0);
		av(1'b1, pdh_pkg::REG_MASK, 32'h2);
		av(1'b0, pdh_pkg::REG_CTRL, 32'h0);
		check("ctrl", q, 32'h4);
		check("irq_rx", 32'(completion_irq_request_out), 32'h1);
		av(1'b0, pdh_pkg::REG_STATE, 32'h0);
		check("state_idle", q, 32'h0);
		final_report();
	end
endmodule
